// ---- rte_top.sv ----
// rf transmit encoder controller: apb registers, ram fetch fsm, line encoder, pll/pa control
// Overview of operation
// (RULE1) bytes from the processor side are encoded and shifted out serially
// (RULE2) config bit1 clear: bit0 set mark space, else bit2 picks manchester or pwm
// (RULE3) config bit1 set: bit0 picks bi-phase or differential bi-phase, bit2 variant
// (RULE4) manchester and mark space rate is clock /4, /16, /8, /2 by bits 7:6
// (RULE5) pwm rate is clock /6, /24, /12, /3 by bits 7:6
// (RULE6) synthesized frequency is reference times divider plus 13-bit fraction over 2^13
// (RULE7) integer divider is 26 on the low band and 36 on the high band
// (RULE8) amplitude keying uses frequency word 0 alone
// (RULE9) frequency keying sends word 0 for zero bits and word 1 for one bits
// (RULE10) software loads frequency words before transmission starts
// (RULE11) pll and pa controls follow the serial encoded stream
// (RULE12) amplitude keying toggles pa enable with the serial data
// (RULE13) frequency keying enables pa after pll lock for the whole transmission
// (RULE14) pll lock loss during transmission mutes the pa
// (RULE15) pll lock loss during transmission raises the lock-loss alarm
// (RULE16) payload is fetched from ram starting at 0x80 without cpu help
// (RULE17) cpu is held halted while the fsm accesses ram
// (RULE18) during transmission the fsm powers pll, crystal oscillator and encoder
// (RULE19) a rate counter makes a one-cycle tick that advances the encoder
// (RULE20) after the programmed byte count the rf path powers down, cpu released
`timescale 1ns/10ps
module rte_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic ram_rd_en,
  output logic [7:0] ram_addr,
  input wire logic [7:0] ram_rdata,
  output logic cpu_halt,
  output logic xtal_en,
  output logic pll_en,
  output logic encoder_en,
  output logic pa_en,
  output logic fsk_data,
  output logic [12:0] fractional_word,
  output logic [5:0] int_divider,
  output logic high_band_select,
  input wire logic pll_lock,
  output logic lock_alarm
);
  typedef struct packed {
    rte_pkg::rte_state_t st;
    logic [7:0] cfg;
    logic [12:0] fw0;
    logic [12:0] fw1;
    logic [7:0] rfc;
    logic [7:0] len;
    logic [7:0] sent;
    logic [7:0] fetched;
    logic [7:0] shreg;
    logic [7:0] nxt;
    logic rd_en;
    logic rd_pend;
    logic [7:0] raddr;
    logic [2:0] bitn;
    logic [1:0] cidx;
    logic [2:0] pat;
    logic p3;
    logic [3:0] cnt;
    logic out;
    logic mute;
    logic alarm;
    logic [12:0] frac;
    logic [31:0] prdata;
  } rte_regs_t;

  rte_regs_t r_q;
  rte_regs_t r_d;

  // chip pattern of one bit: [3] three chips, [2:0] chips, first in bit 0
  function automatic logic [3:0] chip_pat(input rte_pkg::rte_mode_t m, input logic b,
                                          input logic l);
    logic f;
    f = 1'b0;
    chip_pat = 4'h0;
    unique case (m)
      rte_pkg::MODE_MANCHESTER: chip_pat = {2'b00, ~b, b};
      rte_pkg::MODE_PWM: chip_pat = {2'b10, b, 1'b1};
      rte_pkg::MODE_MARK_SPACE: chip_pat = {1'b0, {3{l ^ b}}};
      rte_pkg::MODE_BIPHASE0: chip_pat = {2'b00, (b ? ~l : l), ~l};
      rte_pkg::MODE_BIPHASE1: chip_pat = {2'b00, (b ? l : ~l), ~l};
      rte_pkg::MODE_DIFF_BIPHASE0: begin
        f = b ? l : ~l;
        chip_pat = {2'b00, ~f, f};
      end
      rte_pkg::MODE_DIFF_BIPHASE1: begin
        f = b ? ~l : l;
        chip_pat = {2'b00, ~f, f};
      end
      default: chip_pat = {2'b00, ~b, b};
    endcase
  endfunction

  rte_pkg::rte_mode_t mode;
  logic busy;
  logic on_air;
  logic fsk;
  logic tick;
  logic last_chip;
  logic nb;
  logic [3:0] cp;
  logic [3:0] cp0;
  logic setup_ph;
  logic wr_acc;
  logic mapped;

  always_comb begin
    if (!r_q.cfg[rte_pkg::CFG_BIPHASE]) begin
      if (r_q.cfg[rte_pkg::CFG_MARK_SPACE]) begin
        mode = rte_pkg::MODE_MARK_SPACE; // see (RULE2)
      end else if (r_q.cfg[rte_pkg::CFG_VARIANT]) begin
        mode = rte_pkg::MODE_PWM; // see (RULE2)
      end else begin
        mode = rte_pkg::MODE_MANCHESTER; // see (RULE2)
      end
    end else if (!r_q.cfg[rte_pkg::CFG_MARK_SPACE]) begin
      mode = r_q.cfg[rte_pkg::CFG_VARIANT] ? rte_pkg::MODE_BIPHASE1
                                            : rte_pkg::MODE_BIPHASE0; // see (RULE3)
    end else begin
      mode = r_q.cfg[rte_pkg::CFG_VARIANT] ? rte_pkg::MODE_DIFF_BIPHASE1
                                            : rte_pkg::MODE_DIFF_BIPHASE0; // see (RULE3)
    end
  end

  assign busy = (r_q.st != rte_pkg::ST_IDLE);
  assign on_air = (r_q.st == rte_pkg::ST_FETCH) || (r_q.st == rte_pkg::ST_LOAD)
                  || (r_q.st == rte_pkg::ST_SEND);
  assign fsk = r_q.rfc[rte_pkg::RFC_FSK];
  // chips last 2,8,4,1 clocks: two chips per bit gives /4../2, three gives /6../3
  assign tick = (r_q.cnt == rte_pkg::CHIP_LEN[r_q.cfg[rte_pkg::CFG_RATE_HI:rte_pkg::CFG_RATE_LO]]
                 - 4'h1); // see (RULE19) (RULE4) (RULE5)
  assign last_chip = (r_q.cidx == (r_q.p3 ? 2'd2 : 2'd1));
  assign nb = (r_q.bitn != 3'd7) ? r_q.shreg[6] : r_q.nxt[7];
  assign cp = chip_pat(mode, nb, r_q.out);
  assign cp0 = chip_pat(mode, ram_rdata[7], 1'b0);
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;

  always_comb begin
    unique case (paddr)
      rte_pkg::OFS_ENC_CFG, rte_pkg::OFS_FREQ0, rte_pkg::OFS_FREQ1, rte_pkg::OFS_RF_CTRL,
      rte_pkg::OFS_TX_LEN, rte_pkg::OFS_TX_CMD, rte_pkg::OFS_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    r_d = r_q;
    r_d.rd_en = 1'b0;
    r_d.rd_pend = r_q.rd_en;
    // register writes; setup is frozen while a frame runs
    if (wr_acc && !busy) begin
      unique case (paddr)
        rte_pkg::OFS_ENC_CFG: r_d.cfg = pwdata[7:0];
        rte_pkg::OFS_FREQ0: r_d.fw0 = pwdata[12:0]; // see (RULE10)
        rte_pkg::OFS_FREQ1: r_d.fw1 = pwdata[12:0]; // see (RULE10)
        rte_pkg::OFS_RF_CTRL: r_d.rfc = pwdata[7:0];
        rte_pkg::OFS_TX_LEN: r_d.len = (pwdata[7:0] > rte_pkg::MAX_BYTES) ? rte_pkg::MAX_BYTES
                                                                         : pwdata[7:0];
        rte_pkg::OFS_TX_CMD: begin
          if (pwdata[rte_pkg::CMD_START] && r_q.len != 8'h00) begin
            r_d.st = rte_pkg::ST_WARM; // see (RULE18)
            r_d.mute = 1'b0;
            r_d.sent = 8'h00;
            r_d.fetched = 8'h00;
          end
        end
        default: r_d.st = r_q.st;
      endcase
    end
    unique case (r_q.st)
      rte_pkg::ST_IDLE: r_d.out = 1'b0;
      rte_pkg::ST_WARM: begin
        if (pll_lock) begin
          r_d.st = rte_pkg::ST_FETCH; // see (RULE13)
        end
      end
      rte_pkg::ST_FETCH: begin
        r_d.rd_en = 1'b1; // see (RULE16)
        r_d.raddr = rte_pkg::RAM_BASE;
        r_d.fetched = 8'h01;
        r_d.st = rte_pkg::ST_LOAD;
      end
      rte_pkg::ST_LOAD: begin
        if (r_q.rd_pend) begin
          r_d.shreg = ram_rdata; // see (RULE1)
          r_d.bitn = 3'd0;
          r_d.cidx = 2'd0;
          r_d.pat = cp0[2:0];
          r_d.p3 = cp0[3];
          r_d.out = cp0[0];
          r_d.cnt = 4'h0;
          r_d.st = rte_pkg::ST_SEND;
          if (r_q.len > 8'h01) begin
            r_d.rd_en = 1'b1; // see (RULE16)
            r_d.raddr = rte_pkg::RAM_BASE + {1'b0, r_q.fetched[6:0]};
            r_d.fetched = r_q.fetched + 8'h01;
          end
        end
      end
      rte_pkg::ST_SEND: begin
        if (r_q.rd_pend) begin
          r_d.nxt = ram_rdata;
        end
        r_d.cnt = tick ? 4'h0 : r_q.cnt + 4'h1;
        if (tick) begin
          if (!last_chip) begin
            r_d.cidx = r_q.cidx + 2'd1; // see (RULE19)
            r_d.out = r_q.pat[r_q.cidx + 2'd1];
          end else if (r_q.bitn != 3'd7 || r_q.sent + 8'h01 < r_q.len) begin
            r_d.cidx = 2'd0;
            r_d.pat = cp[2:0]; // see (RULE1)
            r_d.p3 = cp[3];
            r_d.out = cp[0];
            r_d.bitn = r_q.bitn + 3'd1;
            if (r_q.bitn != 3'd7) begin
              r_d.shreg = {r_q.shreg[6:0], 1'b0};
            end else begin
              r_d.shreg = r_q.nxt;
              r_d.sent = r_q.sent + 8'h01;
              if (r_q.fetched < r_q.len) begin
                r_d.rd_en = 1'b1; // see (RULE16)
                r_d.raddr = rte_pkg::RAM_BASE + {1'b0, r_q.fetched[6:0]};
                r_d.fetched = r_q.fetched + 8'h01;
              end
            end
          end else begin
            r_d.sent = r_q.sent + 8'h01;
            r_d.out = 1'b0;
            r_d.st = rte_pkg::ST_DONE; // see (RULE20)
          end
        end
      end
      rte_pkg::ST_DONE: r_d.st = rte_pkg::ST_IDLE; // see (RULE20)
      default: r_d.st = rte_pkg::ST_IDLE;
    endcase
    // lock loss on air: mute pa, raise sticky alarm; a new loss beats a clear
    if (wr_acc && paddr == rte_pkg::OFS_STATUS && pwdata[rte_pkg::STAT_ALARM]) begin
      r_d.alarm = 1'b0;
    end
    if (on_air && !pll_lock) begin
      r_d.mute = 1'b1; // see (RULE14)
      r_d.alarm = 1'b1; // see (RULE15)
    end
    // frequency word follows the serial data in fsk, word 0 otherwise
    r_d.frac = (fsk && r_d.st == rte_pkg::ST_SEND && r_d.out) ? r_q.fw1
                                                               : r_q.fw0; // see (RULE8) (RULE9)
    if (setup_ph) begin
      r_d.prdata = 32'h0000_0000;
      unique case (paddr)
        rte_pkg::OFS_ENC_CFG: r_d.prdata[7:0] = r_q.cfg;
        rte_pkg::OFS_FREQ0: r_d.prdata[12:0] = r_q.fw0;
        rte_pkg::OFS_FREQ1: r_d.prdata[12:0] = r_q.fw1;
        rte_pkg::OFS_RF_CTRL: r_d.prdata[7:0] = r_q.rfc;
        rte_pkg::OFS_TX_LEN: r_d.prdata[7:0] = r_q.len;
        rte_pkg::OFS_STATUS: begin
          r_d.prdata[rte_pkg::STAT_BUSY] = busy;
          r_d.prdata[rte_pkg::STAT_ALARM] = r_q.alarm;
          r_d.prdata[rte_pkg::STAT_SENT_LO +: 8] = r_q.sent;
        end
        default: r_d.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '{st: rte_pkg::ST_IDLE, cfg: rte_pkg::ENC_CFG_RST, fw0: rte_pkg::FREQ_RST,
               fw1: rte_pkg::FREQ_RST, rfc: rte_pkg::RF_CTRL_RST, len: rte_pkg::TX_LEN_RST,
               frac: rte_pkg::FREQ_RST, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign prdata = r_q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign ram_rd_en = r_q.rd_en;
  assign ram_addr = r_q.raddr;
  assign cpu_halt = busy; // see (RULE17)
  assign xtal_en = busy && (r_q.st != rte_pkg::ST_DONE); // see (RULE18)
  assign pll_en = xtal_en; // see (RULE18) (RULE11)
  assign encoder_en = on_air; // see (RULE18)
  // ask keys the pa with the chips; fsk holds it on for the frame (RULE12 RULE13 RULE14)
  assign pa_en = !r_q.mute && (fsk ? on_air
                                   : (r_q.st == rte_pkg::ST_SEND && r_q.out)); // see (RULE12) (RULE13) (RULE11)
  assign fsk_data = r_q.out; // see (RULE11)
  assign fractional_word = r_q.frac; // see (RULE6)
  assign high_band_select = r_q.rfc[rte_pkg::RFC_HIGH_BAND];
  assign int_divider = high_band_select ? rte_pkg::DIV_HIGH_BAND
                                        : rte_pkg::DIV_LOW_BAND; // see (RULE7)
  assign lock_alarm = r_q.alarm; // see (RULE15)
endmodule

// ---- rte_pkg.sv ----
// constants and types shared by the rf transmit encoder controller
package rte_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_ENC_CFG = 8'h00;
  localparam logic [7:0] OFS_FREQ0 = 8'h04;
  localparam logic [7:0] OFS_FREQ1 = 8'h08;
  localparam logic [7:0] OFS_RF_CTRL = 8'h0c;
  localparam logic [7:0] OFS_TX_LEN = 8'h10;
  localparam logic [7:0] OFS_TX_CMD = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // field positions
  localparam int CFG_MARK_SPACE = 0;
  localparam int CFG_BIPHASE = 1;
  localparam int CFG_VARIANT = 2;
  localparam int CFG_RATE_LO = 6;
  localparam int CFG_RATE_HI = 7;
  localparam int RFC_FSK = 0;
  localparam int RFC_HIGH_BAND = 7;
  localparam int CMD_START = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ALARM = 1;
  localparam int STAT_SENT_LO = 8;
  // reset values
  localparam logic [7:0] ENC_CFG_RST = 8'h00;
  localparam logic [12:0] FREQ_RST = 13'h0000;
  localparam logic [7:0] RF_CTRL_RST = 8'h00;
  localparam logic [7:0] TX_LEN_RST = 8'h00;
  // synthesizer integer divider per band
  localparam logic [5:0] DIV_LOW_BAND = 6'h1a;
  localparam logic [5:0] DIV_HIGH_BAND = 6'h24;
  // payload window in upper data ram
  localparam logic [7:0] RAM_BASE = 8'h80;
  localparam logic [7:0] MAX_BYTES = 8'h80;
  // clocks per chip for rate codes 00,01,10,11 (2-chip codes: /4,/16,/8,/2; pwm: /6,/24,/12,/3)
  localparam logic [3:0] CHIP_LEN [4] = '{4'h2, 4'h8, 4'h4, 4'h1};

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_WARM = 6'h02,
    ST_FETCH = 6'h04,
    ST_LOAD = 6'h08,
    ST_SEND = 6'h10,
    ST_DONE = 6'h20
  } rte_state_t;

  typedef enum logic [2:0] {
    MODE_MANCHESTER = 3'h0,
    MODE_PWM = 3'h1,
    MODE_MARK_SPACE = 3'h2,
    MODE_BIPHASE0 = 3'h3,
    MODE_BIPHASE1 = 3'h4,
    MODE_DIFF_BIPHASE0 = 3'h5,
    MODE_DIFF_BIPHASE1 = 3'h6
  } rte_mode_t;
endpackage

// ---- rte_top_checker.sv ----
// concurrent checks on the ports of the rf transmit encoder controller
`timescale 1ns/10ps
module rte_top_checker (
  input logic pclk,
  input logic presetn,
  input logic ram_rd_en,
  input logic [7:0] ram_addr,
  input logic cpu_halt,
  input logic xtal_en,
  input logic pll_en,
  input logic encoder_en,
  input logic pa_en,
  input logic fsk_data,
  input logic [5:0] int_divider,
  input logic high_band_select,
  input logic pll_lock,
  input logic lock_alarm
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  div_band_a: assert property (int_divider == (high_band_select ? 6'h24 : 6'h1a))
    else $error("divider does not follow band select");
  fetch_halt_a: assert property (ram_rd_en |-> cpu_halt && ram_addr[7])
    else $error("ram fetch outside halt or upper bank");
  air_power_a: assert property (encoder_en |-> xtal_en && pll_en && cpu_halt)
    else $error("rf path unpowered while encoding");
  pa_after_pll_a: assert property (pa_en |-> pll_en && encoder_en)
    else $error("pa enabled without pll");
  lock_mute_a: assert property (encoder_en && !pll_lock |=> !pa_en)
    else $error("pa not muted after lock loss");
  lock_alarm_a: assert property (encoder_en && !pll_lock |=> lock_alarm)
    else $error("alarm missing after lock loss");
  idle_quiet_a: assert property (!encoder_en |-> !fsk_data && !pa_en)
    else $error("serial line active outside frame");
  cpu_release_a: assert property ($fell(cpu_halt) |-> !xtal_en && !$past(xtal_en))
    else $error("cpu released before rf power down");
endmodule
bind rte_top rte_top_checker u_chk (
  .pclk(pclk), .presetn(presetn), .ram_rd_en(ram_rd_en), .ram_addr(ram_addr),
  .cpu_halt(cpu_halt), .xtal_en(xtal_en), .pll_en(pll_en), .encoder_en(encoder_en),
  .pa_en(pa_en), .fsk_data(fsk_data), .int_divider(int_divider),
  .high_band_select(high_band_select), .pll_lock(pll_lock), .lock_alarm(lock_alarm)
);

// ---- rte_rf_model.sv ----
// behavioural data ram and pll lock model facing the rf transmit encoder controller
`timescale 1ns/10ps
module rte_rf_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  output logic [7:0] rdata,
  input wire logic pll_en,
  input wire logic drop,
  output logic lock
);
  logic [7:0] mem [256];
  logic [2:0] settle;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
      settle <= 3'h0;
      lock <= 1'b0;
    end else begin
      // one cycle read latency; between reads the line inverts its last value every cycle
      rdata <= rd_en ? mem[addr] : ~rdata;
      settle <= (!pll_en || drop) ? 3'h0 : settle + {2'h0, settle != 3'h7};
      lock <= pll_en && !drop && settle >= 3'h4;
    end
  end
endmodule

// ---- testbench.sv ----
// self-checking bench for the rf transmit encoder controller
`timescale 1ns/10ps
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic drop = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ram_rd_en, cpu_halt, xtal_en, pll_en, encoder_en, pa_en, fsk_data;
  logic high_band_select, pll_lock, lock_alarm, fsk, lv, c;
  logic [7:0] ram_addr, ram_rdata, byt;
  logic [12:0] fractional_word, fw0, fw1;
  logic [5:0] int_divider;
  logic [1:0] rate;
  logic [32:0] rq [$];
  logic cq [$];
  logic [31:0] lfsr = 32'd69008;
  logic [2:0] cfgtab [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  always #2.5 pclk = ~pclk;
  rte_top u_rte_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ram_rd_en(ram_rd_en), .ram_addr(ram_addr), .ram_rdata(ram_rdata),
    .cpu_halt(cpu_halt), .xtal_en(xtal_en), .pll_en(pll_en), .encoder_en(encoder_en),
    .pa_en(pa_en), .fsk_data(fsk_data), .fractional_word(fractional_word),
    .int_divider(int_divider), .high_band_select(high_band_select), .pll_lock(pll_lock),
    .lock_alarm(lock_alarm));
  rte_rf_model u_rte_rf_model (.clk(pclk), .rst_n(presetn), .rd_en(ram_rd_en),
    .addr(ram_addr), .rdata(ram_rdata), .pll_en(pll_en), .drop(drop), .lock(pll_lock));
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // expected chips of one byte, msb first, lv carries the last chip level
  function automatic void enc(input logic [2:0] m, input logic [7:0] d);
    logic b;
    logic c1;
    logic c2;
    for (int k = 7; k >= 0; k--) begin
      b = d[k];
      if (m[1]) begin
        c1 = m[0] ? ((b == m[2]) ? ~lv : lv) : ~lv;
        c2 = m[0] ? ~c1 : ((b ^ m[2]) ? c1 : ~c1);
      end else if (m[0]) begin
        c1 = b ? ~lv : lv;
        c2 = c1;
      end else if (m[2]) begin
        cq.push_back(1'b1);
        c1 = b;
        c2 = 1'b0;
      end else begin
        c1 = b;
        c2 = ~b;
      end
      cq.push_back(c1);
      cq.push_back(c2);
      lv = c2;
    end
  endfunction
  task chk(input string nm, input logic [32:0] e, input logic [32:0] s);
    n_compared++;
    if (e !== s) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task end_sim;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    if (!w) rq.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      end_sim;
    end
    if (psel && penable && pready && !pwrite && rq.size() > 0) begin
      chk("prdata", rq.pop_front(), {pslverr, prdata});
    end
  end
  initial forever begin
    wait (encoder_en === 1'b1);
    if (cq.size() > 0) begin
      // fetch takes one cycle and load two, so the first chip shows three cycles after encoder_en
      repeat (4) @(negedge pclk);
      while (cq.size() > 0) begin
        c = cq.pop_front();
        chk("fsk_data", c, fsk_data);
        chk("pa_en", fsk | c, pa_en);
        chk("fractional_word", (fsk && c) ? fw1 : fw0, fractional_word);
        repeat (rte_pkg::CHIP_LEN[rate]) @(negedge pclk);
      end
    end
    wait (encoder_en === 1'b0);
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 8; a++) apb(1'b0, 8'(a * 4), 32'h0, {a == 7, 32'h0});
    apb(1'b1, rte_pkg::OFS_TX_CMD, 32'h1, 33'h0);
    apb(1'b0, rte_pkg::OFS_STATUS, 32'h0, 33'h0);
    for (int i = 0; i < 8; i++) begin
      rate = 2'(i);
      fsk = i[0];
      fw0 = 13'(rnd());
      fw1 = 13'(rnd());
      apb(1'b1, rte_pkg::OFS_ENC_CFG, {24'h0, rate, 3'h0, cfgtab[i]}, 33'h0);
      apb(1'b1, rte_pkg::OFS_FREQ0, {19'h0, fw0}, 33'h0);
      apb(1'b1, rte_pkg::OFS_FREQ1, {19'h0, fw1}, 33'h0);
      apb(1'b1, rte_pkg::OFS_RF_CTRL, {24'h0, i[1], 6'h0, fsk}, 33'h0);
      chk("int_divider", i[1] ? 6'd36 : 6'd26, int_divider);
      apb(1'b1, rte_pkg::OFS_TX_LEN, 32'h2, 33'h0);
      lv = 1'b0;
      for (int b = 0; b < 2; b++) begin
        byt = 8'(rnd());
        u_rte_rf_model.mem[8'h80 + b] = byt;
        enc(cfgtab[i], byt);
      end
      apb(1'b1, rte_pkg::OFS_TX_CMD, 32'h1, 33'h0);
      while (cpu_halt !== 1'b0) @(posedge pclk);
      apb(1'b0, rte_pkg::OFS_STATUS, 32'h0, 33'h0200);
    end
    // the lock loss frame sends four bytes; give the last two defined values
    for (int b = 2; b < 4; b++) u_rte_rf_model.mem[8'h80 + b] = 8'(rnd());
    apb(1'b1, rte_pkg::OFS_TX_LEN, 32'h4, 33'h0);
    apb(1'b1, rte_pkg::OFS_TX_CMD, 32'h1, 33'h0);
    wait (encoder_en === 1'b1);
    repeat (6) @(posedge pclk);
    drop <= 1'b1;
    repeat (3) @(posedge pclk);
    drop <= 1'b0;
    while (cpu_halt !== 1'b0) @(posedge pclk);
    apb(1'b0, rte_pkg::OFS_STATUS, 32'h0, 33'h0402);
    apb(1'b1, rte_pkg::OFS_STATUS, 32'h2, 33'h0);
    apb(1'b0, rte_pkg::OFS_STATUS, 32'h0, 33'h0400);
    end_sim;
  end
endmodule
